// >>> logic/adc_ext_clock_host_serial_port.sv
// host sequencer driving the converter serial port in external clock mode
//
// Functional notes
// [R1] tied wiring: every write goes to control register
// [R2] tied wiring: reads get output or calibration data
// [R3] tied wiring: control register cannot be read back
// [R4] transmit sync may be inverted receive sync
// [R5] never derive receive sync from transmit sync
// [R6] data reads wait for word available low
// [R7] output word fetched whole or in bytes
// [R8] control and calibration reads ignore word available
// [R9] control read: select low with receive sync
// [R10] converter shifts read words out MSB first
// [R11] writes send MSB of word first
// [R12] writes may be sent as byte pieces
// [R13] byte split: reverse bits per byte separately
// [R14] host supplies serial clock, converter external clocked
// [R15] idle: both syncs and select high, three bytes
// [R16] word available rises after last bit read
// [R17] select low control, high output or calibration
// [R18] MSB after sync falls, next bits on falling edges
// [R19] writes are exactly 24 bits, sampled clock high
// [R20] never both frame syncs low together
`timescale 1ns/100ps
module adc_ext_clock_host_serial_port
	import adc_host_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	// user command
	input wire logic cmd_valid,
	input wire cmd_kind_type cmd_kind,
	input wire logic [`WORD_BITS-1:0] cmd_wdata,
	output logic cmd_ready,
	// user options, taken with each command
	input wire logic cfg_tied_select,
	input wire logic cfg_byte_split,
	input wire logic cfg_lsb_first,
	// user answer
	output logic rsp_valid,
	output logic [`WORD_BITS-1:0] rsp_data,
	output logic cmd_refused,
	output logic word_stuck,
	// converter pins
	output logic adc_sclk,
	output logic receive_frame_sync_n,
	output logic transmit_frame_sync_n,
	output logic register_select,
	input wire logic serial_io_line_in,
	output logic serial_io_line_out,
	output logic serial_io_line_oe,
	input wire logic word_available_n
);

	host_state_type s_r;
	host_state_type s_nxt;
	logic [`SYNC_W-1:0] pins_async;
	logic [`SYNC_W-1:0] pins_sync;
	logic sdi_s;
	logic rdy_n_s;
	logic run;
	logic tick;
	logic bad_kind;
	logic is_write_cmd;
	logic sel_level;
	logic last_bit;
	logic byte_edge;
	logic [`WORD_BITS-1:0] sampled;
	logic [`WORD_BITS-1:0] shifted;
	logic [`WORD_BITS-1:0] word_out;

	// pins from the converter pass two flops first
	assign pins_async[`SYNC_SDI] = serial_io_line_in;
	assign pins_async[`SYNC_RDY] = word_available_n;

	adc_pin_sync u_sync (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.pins_async(pins_async),
		.pins_sync(pins_sync)
	);

	assign sdi_s = pins_sync[`SYNC_SDI];
	assign rdy_n_s = pins_sync[`SYNC_RDY];

	// the host makes the serial clock from its own clock
	assign run = (s_r.st != ST_IDLE) && (s_r.st != ST_WAIT_RDY); // [R14]

	adc_sclk_divider u_div (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.run(run),
		.tick(tick)
	);

	// command decode
	assign is_write_cmd = (cmd_kind == CMD_WRITE_CTRL) ||
		(cmd_kind == CMD_WRITE_CAL);

	// kinds the wiring cannot carry, or unknown codes
	always_comb begin
		case (cmd_kind)
			CMD_READ_DATA: bad_kind = 1'b0;
			CMD_READ_CAL: bad_kind = 1'b0;
			CMD_WRITE_CTRL: bad_kind = 1'b0;
			CMD_READ_CTRL: bad_kind = cfg_tied_select; // [R3]
			CMD_WRITE_CAL: bad_kind = cfg_tied_select; // [R1]
			default: bad_kind = 1'b1;
		endcase
	end

	// select level: low for control, high for output or calibration
	assign sel_level = !((cmd_kind == CMD_READ_CTRL) ||
		(cmd_kind == CMD_WRITE_CTRL)); // [R17] [R9]

	// bit position checks at the end of a low half period
	assign last_bit = (s_r.bitn == `BIT_CNT_W'(`WORD_BITS)); // [R19]
	assign byte_edge = s_r.byte_mode &&
		(s_r.bitn[`BYTE_LSB_W-1:0] == `BYTE_LSB_W'(0)); // [R7] [R12]

	// read data shifts in MSB first at the rising clock edge
	assign sampled = {s_r.shreg[`WORD_LAST_BIT-1:0], sdi_s}; // [R10]
	// write data moves to the next bit at the falling clock edge
	assign shifted = {s_r.shreg[`WORD_LAST_BIT-1:0], 1'b0}; // [R11]

	// received word, bits reordered per byte when asked
	assign word_out = s_r.lsb_first ? reverse_in_bytes(s_r.shreg) :
		s_r.shreg; // [R13]

	// transfer sequencer
	always_comb begin
		s_nxt = s_r;
		s_nxt.rsp_valid = 1'b0;
		s_nxt.refused = 1'b0;
		s_nxt.stuck = 1'b0;
		case (s_r.st)
			// wait for a command with all lines at rest
			ST_IDLE: begin
				s_nxt.sclk = `SCLK_IDLE;
				s_nxt.rfs_n = `PIN_IDLE;
				s_nxt.tfs_n = `PIN_IDLE;
				s_nxt.rsel = `PIN_IDLE; // [R15]
				if (cmd_valid && bad_kind) begin
					s_nxt.refused = 1'b1;
				end else if (cmd_valid) begin
					s_nxt.kind = cmd_kind;
					s_nxt.is_write = is_write_cmd;
					s_nxt.byte_mode = cfg_byte_split;
					s_nxt.lsb_first = cfg_lsb_first;
					s_nxt.tied = cfg_tied_select;
					s_nxt.bitn = '0;
					s_nxt.ready = 1'b0;
					s_nxt.shreg = cfg_lsb_first ?
						reverse_in_bytes(cmd_wdata) : cmd_wdata; // [R13]
					s_nxt.rsel = sel_level; // [R9] [R17]
					if (cmd_kind == CMD_READ_DATA) begin
						s_nxt.st = ST_WAIT_RDY;
					end else begin
						s_nxt.st = ST_SETUP; // [R8]
					end
				end
			end
			// data reads start only once a word is available
			ST_WAIT_RDY: begin
				if (!rdy_n_s) begin
					s_nxt.st = ST_SETUP; // [R6]
				end
			end
			// untied select settles for one half period before the frame, a tied one follows the transmit sync
			ST_SETUP: begin
				if (tick) begin
					s_nxt.st = ST_LEAD;
					if (s_r.is_write) begin
						s_nxt.tfs_n = 1'b0;
						s_nxt.sdo = s_r.shreg[`WORD_LAST_BIT]; // [R11]
						s_nxt.sdo_oe = 1'b1;
					end else begin
						s_nxt.rfs_n = 1'b0; // [R18] [R20]
					end
				end
			end
			// frame open, clock low; the converter shows its MSB
			ST_LEAD: begin
				if (tick) begin
					s_nxt.st = ST_HIGH;
					s_nxt.sclk = 1'b1;
					if (!s_r.is_write) begin
						s_nxt.shreg = sampled; // [R18]
					end
				end
			end
			// clock high; the converter takes the write bit here
			ST_HIGH: begin
				if (tick) begin
					s_nxt.st = ST_LOW;
					s_nxt.sclk = 1'b0;
					s_nxt.bitn = s_r.bitn + `BIT_CNT_W'(1);
					if (s_r.is_write) begin
						s_nxt.shreg = shifted;
						s_nxt.sdo = s_r.shreg[`WORD_LAST_BIT-1]; // [R19]
					end
				end
			end
			// clock low; end the word, pause between bytes, or go on
			ST_LOW: begin
				if (tick) begin
					if (last_bit) begin
						s_nxt.st = ST_DONE;
						s_nxt.rfs_n = `PIN_IDLE;
						s_nxt.tfs_n = `PIN_IDLE;
						s_nxt.sdo_oe = 1'b0;
						s_nxt.sdo = 1'b0;
					end else if (byte_edge) begin
						s_nxt.st = ST_GAP; // [R7] [R12]
						s_nxt.rfs_n = `PIN_IDLE;
						s_nxt.tfs_n = `PIN_IDLE;
					end else begin
						s_nxt.st = ST_HIGH;
						s_nxt.sclk = 1'b1;
						if (!s_r.is_write) begin
							s_nxt.shreg = sampled; // [R18]
						end
					end
				end
			end
			// frame sync back high between bytes, clock stays low
			ST_GAP: begin
				if (tick) begin
					s_nxt.st = ST_LEAD;
					if (s_r.is_write) begin
						s_nxt.tfs_n = 1'b0;
					end else begin
						s_nxt.rfs_n = 1'b0; // [R20]
					end
				end
			end
			// frame syncs and a tied select at rest for one half period, untied select released on leaving along with the answer
			ST_DONE: begin
				if (tick) begin
					s_nxt.st = ST_IDLE;
					s_nxt.ready = 1'b1;
					s_nxt.rsel = `PIN_IDLE; // [R15]
					if (!s_r.is_write) begin
						s_nxt.rsp_valid = 1'b1;
						s_nxt.rsp_data = word_out;
					end
					// after a data word the converter must have let go
					if (s_r.kind == CMD_READ_DATA && !rdy_n_s) begin
						s_nxt.stuck = 1'b1; // [R16]
					end
				end
			end
			default: begin
				s_nxt.st = ST_IDLE;
				s_nxt.ready = 1'b1;
				s_nxt.rfs_n = `PIN_IDLE;
				s_nxt.tfs_n = `PIN_IDLE;
				s_nxt.sdo_oe = 1'b0;
			end
		endcase
		// tied wiring: select line always equals the transmit sync
		if (s_nxt.tied) begin
			s_nxt.rsel = s_nxt.tfs_n; // [R1] [R2]
		end
	end

	// state register; the receive sync is never made from the
	// transmit sync, both are driven on their own
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			s_r <= '0;
			s_r.st <= ST_IDLE;
			s_r.kind <= CMD_READ_DATA;
			s_r.sclk <= `SCLK_IDLE;
			s_r.rfs_n <= `PIN_IDLE; // [R5]
			s_r.tfs_n <= `PIN_IDLE; // [R4]
			s_r.rsel <= `PIN_IDLE;
			s_r.ready <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// all outputs straight from the state register
	assign cmd_ready = s_r.ready;
	assign rsp_valid = s_r.rsp_valid;
	assign rsp_data = s_r.rsp_data;
	assign cmd_refused = s_r.refused;
	assign word_stuck = s_r.stuck;
	assign adc_sclk = s_r.sclk;
	assign receive_frame_sync_n = s_r.rfs_n;
	assign transmit_frame_sync_n = s_r.tfs_n;
	assign register_select = s_r.rsel;
	assign serial_io_line_out = s_r.sdo;
	assign serial_io_line_oe = s_r.sdo_oe;

endmodule // adc_ext_clock_host_serial_port

// >>> logic/adc_host_regs.svh
// timing and layout constants of the serial port host
`ifndef ADC_HOST_REGS_SVH
`define ADC_HOST_REGS_SVH

// system clock period and wanted serial clock period, in ns
`define CLK_PERIOD_NS 4
`define SCLK_PERIOD_NS 80
// half serial clock period in system clock cycles (rounded down, min 1)
`define SCLK_HALF_CYC (((`SCLK_PERIOD_NS / `CLK_PERIOD_NS) / 2) > 0 ? \
	((`SCLK_PERIOD_NS / `CLK_PERIOD_NS) / 2) : 1)
`define DIV_CNT_W 8

// word layout
`define WORD_BITS 24
`define BYTE_BITS 8
`define BIT_CNT_W 5
`define WORD_LAST_BIT 23
`define BYTE_LSB_W 3

// reset and idle levels of the pins
`define PIN_IDLE 1'b1
`define SCLK_IDLE 1'b0
`define SYNC_W 2
`define SYNC_RST 2'b11
`define SYNC_SDI 0
`define SYNC_RDY 1

`endif

// >>> logic/adc_host_pkg.sv
// types and helpers shared by the serial port host modules
package adc_host_pkg;
`include "adc_host_regs.svh"

	// sequencer states, gray coded in the order listed, not on every transition
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_WAIT_RDY = 3'h1,
		ST_SETUP = 3'h3,
		ST_LEAD = 3'h2,
		ST_HIGH = 3'h6,
		ST_LOW = 3'h7,
		ST_GAP = 3'h5,
		ST_DONE = 3'h4
	} ctl_state_type;

	// transfer kinds the user may request
	typedef enum logic [2:0] {
		CMD_READ_DATA = 3'h0,
		CMD_READ_CTRL = 3'h1,
		CMD_READ_CAL = 3'h2,
		CMD_WRITE_CTRL = 3'h3,
		CMD_WRITE_CAL = 3'h4
	} cmd_kind_type;

	// whole state of the host sequencer
	typedef struct packed {
		ctl_state_type st;
		cmd_kind_type kind;
		logic is_write;
		logic byte_mode;
		logic lsb_first;
		logic tied;
		logic [`BIT_CNT_W-1:0] bitn;
		logic [`WORD_BITS-1:0] shreg;
		logic sclk;
		logic rfs_n;
		logic tfs_n;
		logic rsel;
		logic sdo;
		logic sdo_oe;
		logic ready;
		logic rsp_valid;
		logic [`WORD_BITS-1:0] rsp_data;
		logic refused;
		logic stuck;
	} host_state_type;

	// state of the serial clock divider
	typedef struct packed {
		logic [`DIV_CNT_W-1:0] cnt;
	} div_state_type;

	// state of the pin synchroniser
	typedef struct packed {
		logic [`SYNC_W-1:0] meta;
		logic [`SYNC_W-1:0] stable;
	} sync_state_type;

	// reverse bit order inside each byte, byte order kept
	function automatic logic [`WORD_BITS-1:0] reverse_in_bytes(
		input logic [`WORD_BITS-1:0] w);
		logic [`WORD_BITS-1:0] r;
		r = '0;
		for (int i = 0; i < `WORD_BITS; i++) begin
			r[(i / `BYTE_BITS) * `BYTE_BITS + `BYTE_BITS - 1
				- (i % `BYTE_BITS)] = w[i];
		end
		return r;
	endfunction

endpackage

// >>> logic/adc_pin_sync.sv
// two flip-flop synchroniser for the pins read from the converter
`timescale 1ns/100ps
module adc_pin_sync
	import adc_host_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	// asynchronous pins in, synchronised copies out
	input wire logic [`SYNC_W-1:0] pins_async,
	output logic [`SYNC_W-1:0] pins_sync
);

	sync_state_type s_r;
	sync_state_type s_nxt;
	logic [`SYNC_W-1:0] meta_in;
	logic [`SYNC_W-1:0] stable_in;

	// one chain per pin; the first stage feeds only the second
	genvar b;
	generate
		for (b = 0; b < `SYNC_W; b++) begin : g_bit
			assign meta_in[b] = pins_async[b];
			assign stable_in[b] = s_r.meta[b];
		end
	endgenerate

	// next state
	always_comb begin
		s_nxt = s_r;
		s_nxt.meta = meta_in;
		s_nxt.stable = stable_in;
	end

	// state register, idle high after reset
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			s_r <= {`SYNC_RST, `SYNC_RST};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign pins_sync = s_r.stable;

endmodule // adc_pin_sync

// >>> logic/adc_sclk_divider.sv
// half period tick generator for the serial clock
`timescale 1ns/100ps
module adc_sclk_divider
	import adc_host_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	// run enable and half period tick
	input wire logic run,
	output logic tick
);

	div_state_type s_r;
	div_state_type s_nxt;
	logic at_end;

	// last count of a half period
	assign at_end = (s_r.cnt == `DIV_CNT_W'(`SCLK_HALF_CYC - 1));

	// count while running, restart from zero when stopped
	always_comb begin
		s_nxt = s_r;
		if (!run || at_end) begin
			s_nxt.cnt = '0;
		end else begin
			s_nxt.cnt = s_r.cnt + `DIV_CNT_W'(1);
		end
	end

	// counter register
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign tick = run && at_end;

endmodule // adc_sclk_divider

// >>> sim/adc_port_chk.sv
// assertion checker for the converter serial port host
`timescale 1ns/100ps
`include "adc_host_regs.svh"
module adc_port_chk
	import adc_host_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	// user side
	input wire cmd_kind_type cmd_kind,
	input wire logic [`WORD_BITS-1:0] cmd_wdata,
	input wire logic cmd_ready,
	input wire logic cfg_tied_select,
	input wire logic cfg_lsb_first,
	// converter pins
	input wire logic adc_sclk,
	input wire logic receive_frame_sync_n,
	input wire logic transmit_frame_sync_n,
	input wire logic register_select,
	input wire logic serial_io_line_out,
	input wire logic serial_io_line_oe,
	input wire logic word_available_n
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	logic sclk_q;
	logic [5:0] rise_cnt;
	// serial clock rises within one command
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			sclk_q <= 1'b0;
			rise_cnt <= 6'h0;
		end else begin
			sclk_q <= adc_sclk;
			if (cmd_ready)
				rise_cnt <= 6'h0;
			else if (adc_sclk && !sclk_q)
				rise_cnt <= rise_cnt + 6'h1;
		end
	end
	// first write frame opens with the leading bit
	sequence write_open;
		$fell(transmit_frame_sync_n) && rise_cnt == 6'h0;
	endsequence
	sequence lead_bit;
		serial_io_line_out == (cfg_lsb_first ? cmd_wdata[16] : cmd_wdata[23]);
	endsequence
	sync_excl_a: assert property (receive_frame_sync_n || transmit_frame_sync_n)
		else $error("both frame syncs low");
	idle_pins_a: assert property (cmd_ready |-> receive_frame_sync_n && transmit_frame_sync_n && register_select && !adc_sclk && !serial_io_line_oe)
		else $error("pins not idle");
	tied_write_a: assert property (!transmit_frame_sync_n && cfg_tied_select |-> !register_select)
		else $error("tied write select high");
	tied_read_a: assert property (!receive_frame_sync_n && cfg_tied_select |-> register_select)
		else $error("tied read select low");
	data_wait_a: assert property ($fell(receive_frame_sync_n) && cmd_kind == CMD_READ_DATA |-> !$past(word_available_n, 3))
		else $error("read before word flag");
	ctrl_read_a: assert property (!receive_frame_sync_n && cmd_kind == CMD_READ_CTRL |-> !register_select)
		else $error("control read select high");
	bit_count_a: assert property ($rose(cmd_ready) |-> rise_cnt == 6'd24)
		else $error("clock count not 24");
	lead_bit_a: assert property (write_open |-> lead_bit)
		else $error("wrong leading bit");
	data_edge_a: assert property (serial_io_line_oe && $changed(serial_io_line_out) |-> !adc_sclk)
		else $error("data moved with clock high");
	frame_gap_a: assert property ($rose(receive_frame_sync_n) || $rose(transmit_frame_sync_n) |-> !adc_sclk)
		else $error("frame closed with clock high");
endmodule // adc_port_chk
bind adc_ext_clock_host_serial_port adc_port_chk i_chk (.*);

// >>> sim/adc_dev_model.sv
// behavioural converter serial port for the host bench
`timescale 1ns/100ps
module adc_dev_model (
	// pins from the host
	input wire logic clk_sys,
	input wire logic adc_sclk,
	input wire logic receive_frame_sync_n,
	input wire logic transmit_frame_sync_n,
	input wire logic register_select,
	input wire logic serial_io_line_out,
	input wire logic serial_io_line_oe,
	input wire logic stick,
	// data line and word flag
	output logic serial_line,
	output logic word_available_n
);
	logic [23:0] ctrl_r = 24'h0;
	logic [23:0] cal_r = 24'h0;
	logic [23:0] out_r = 24'h0;
	logic [23:0] src_r = 24'h0;
	logic [23:0] in_r = 24'h0;
	logic [4:0] rd_n = 5'h0;
	logic [4:0] wr_n = 5'h0;
	logic from_out = 1'b0;
	logic last = 1'b0;
	initial word_available_n = 1'b1;
	// a new output word becomes pending
	task post_word(input logic [23:0] w);
		out_r = w;
		word_available_n = 1'b0;
	endtask
	// source picked by select as a word starts
	always @(negedge receive_frame_sync_n) begin
		if (rd_n == 5'h0) begin
			from_out = register_select && !word_available_n;
			src_r = !register_select ? ctrl_r : (from_out ? out_r : cal_r);
		end
	end
	// next bit on falling clock, word runs on across frames;
	// the clock comes only from the host, syncs taken separately
	always @(negedge adc_sclk) begin
		if (!receive_frame_sync_n) begin
			if (rd_n == 5'h17) begin
				rd_n = 5'h0;
				if (from_out && !stick)
					word_available_n = 1'b1;
			end else
				rd_n = rd_n + 5'h1;
		end
	end
	// bits taken with clock high, first one lands as MSB
	always @(posedge adc_sclk) begin
		if (!transmit_frame_sync_n) begin
			in_r = {in_r[22:0], serial_line};
			if (wr_n == 5'h17) begin
				wr_n = 5'h0;
				if (register_select)
					cal_r = in_r;
				else
					ctrl_r = in_r;
			end else
				wr_n = wr_n + 5'h1;
		end
	end
	// released line shows a pattern that keeps changing
	always @(posedge clk_sys)
		last <= serial_line;
	assign serial_line = serial_io_line_oe ? serial_io_line_out :
		(!receive_frame_sync_n ? src_r[5'h17 - rd_n] : ~last);
endmodule // adc_dev_model

// >>> sim/adc_ext_clock_host_serial_port_tb_top.sv
// self-checking bench for the converter serial port host
`timescale 1ns/100ps
`include "adc_host_regs.svh"
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin \
	n_errors++; $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module adc_ext_clock_host_serial_port_tb_top
	import adc_host_pkg::*;
;
	typedef struct {
		cmd_kind_type kind;
		logic t, s, l;
		logic [23:0] data, exp;
	} row_type;
	logic clk_sys = 1'b0, arst_n = 1'b0, cmd_valid = 1'b0, stick = 1'b0;
	cmd_kind_type cmd_kind = CMD_READ_DATA;
	logic [`WORD_BITS-1:0] cmd_wdata = 24'h0, got;
	logic cfg_tied_select = 1'b0, cfg_byte_split = 1'b0, cfg_lsb_first = 1'b0;
	logic got_stuck, got_valid, ref_seen, cmd_ready, rsp_valid, cmd_refused, word_stuck;
	logic [`WORD_BITS-1:0] rsp_data;
	logic adc_sclk, receive_frame_sync_n, transmit_frame_sync_n;
	logic register_select, serial_io_line_out, serial_io_line_oe;
	wire serial_io_line_in, word_available_n;
	int n_errors = 0, n_tests = 0, cycles = 0;
	cmd_kind_type bad [3] = '{CMD_READ_CTRL, CMD_WRITE_CAL, cmd_kind_type'(3'h7)};
	row_type rows [8] = '{
		'{CMD_WRITE_CTRL, 1'b0, 1'b0, 1'b0, 24'ha5c31e, 24'ha5c31e},
		'{CMD_WRITE_CAL, 1'b0, 1'b1, 1'b0, 24'h3c960f, 24'h3c960f},
		'{CMD_READ_CTRL, 1'b0, 1'b0, 1'b0, 24'h0, 24'ha5c31e},
		'{CMD_READ_CAL, 1'b0, 1'b1, 1'b1, 24'h0, 24'h3c69f0},
		'{CMD_WRITE_CTRL, 1'b1, 1'b1, 1'b1, 24'h0180f0, 24'h80010f},
		'{CMD_READ_DATA, 1'b0, 1'b0, 1'b0, 24'h81427e, 24'h81427e},
		'{CMD_READ_DATA, 1'b1, 1'b1, 1'b1, 24'h123456, 24'h482c6a},
		'{CMD_READ_CAL, 1'b1, 1'b0, 1'b0, 24'h0, 24'h3c960f}};
	adc_ext_clock_host_serial_port i_adc_ext_clock_host_serial_port (.*);
	adc_dev_model i_adc_dev_model (.clk_sys(clk_sys), .adc_sclk(adc_sclk),
		.receive_frame_sync_n(receive_frame_sync_n),
		.transmit_frame_sync_n(transmit_frame_sync_n),
		.register_select(register_select), .stick(stick),
		.serial_io_line_out(serial_io_line_out),
		.serial_io_line_oe(serial_io_line_oe),
		.serial_line(serial_io_line_in), .word_available_n(word_available_n));
	// clock and cycle ceiling
	always #2 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			close_out();
		end
	end
	// verdict and end of run
	task close_out();
		if (n_errors == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// one command, valid for a single cycle, then wait until the port is idle again
	task automatic run_cmd(input cmd_kind_type k, input logic t, s, l,
		input logic [23:0] w);
		int n;
		n = 0;
		ref_seen = 1'b0;
		@(negedge clk_sys);
		cmd_kind = k;
		cfg_tied_select = t;
		cfg_byte_split = s;
		cfg_lsb_first = l;
		cmd_wdata = w;
		cmd_valid = 1'b1;
		repeat (3) begin
			@(negedge clk_sys);
			cmd_valid = 1'b0;
			ref_seen |= (cmd_refused === 1'b1);
		end
		while (cmd_ready !== 1'b1 && n < 3000) begin
			@(negedge clk_sys);
			n++;
		end
		// a command that never completes counts as a mismatch
		if (n == 3000)
			n_errors++;
		got = rsp_data;
		got_valid = rsp_valid;
		got_stuck = word_stuck;
	endtask
	// reset, table of transfers, then refusals and a stuck flag
	initial begin
		repeat (4) @(posedge clk_sys);
		@(negedge clk_sys);
		arst_n = 1'b1;
		`CHK("idle pins", 6'h2e, {cmd_ready, adc_sclk, receive_frame_sync_n, transmit_frame_sync_n, register_select, serial_io_line_oe})
		foreach (rows[i]) begin
			if (rows[i].kind == CMD_READ_DATA)
				i_adc_dev_model.post_word(rows[i].data);
			run_cmd(rows[i].kind, rows[i].t, rows[i].s, rows[i].l, rows[i].data);
			if (rows[i].kind inside {CMD_WRITE_CTRL, CMD_WRITE_CAL})
				`CHK("stored word", rows[i].exp, rows[i].kind == CMD_WRITE_CAL ? i_adc_dev_model.cal_r : i_adc_dev_model.ctrl_r)
			else
				`CHK("read word", rows[i].exp, got)
			`CHK("stuck flag", 1'b0, got_stuck)
			`CHK("answer strobe", !(rows[i].kind inside {CMD_WRITE_CTRL, CMD_WRITE_CAL}), got_valid)
		end
		foreach (bad[i]) begin
			run_cmd(bad[i], 1'b1, 1'b0, 1'b0, 24'hffffff);
			`CHK("refusal", 2'h3, {ref_seen, cmd_ready})
		end
		`CHK("cal kept", 24'h3c960f, i_adc_dev_model.cal_r)
		stick = 1'b1;
		i_adc_dev_model.post_word(24'h00ff01);
		run_cmd(CMD_READ_DATA, 1'b0, 1'b0, 1'b0, 24'h0);
		`CHK("stuck word", 24'h00ff01, got)
		`CHK("stuck flag", 1'b1, got_stuck)
		`CHK("stuck strobe", 1'b1, got_valid)
		close_out();
	end
endmodule // adc_ext_clock_host_serial_port_tb_top
